// [common/port_pkg.sv]
// Constants and types shared by the power-on reset timer
package port_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned PORT_CLK_HZ = 40_000_000;
	localparam int unsigned PORT_TIMEOUT_MS = 18;
	// Cycles in the nominal time-out; 18 ms at 40 MHz is 720000
	localparam int unsigned PORT_TIMEOUT_CYC = (PORT_CLK_HZ / 1000) * PORT_TIMEOUT_MS;
	localparam int unsigned PORT_CNT_W = 20;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic PORT_LATCH_RST = 1'b1;
	localparam logic [PORT_CNT_W-1:0] PORT_CNT_RST = 20'h00000;

	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PORT_HOLD = 2'b00,
		PORT_COUNT = 2'b01,
		PORT_RUN = 2'b11
	} port_state_e;

endpackage

// [hdl/port_timer.sv]
// Time-out counter of the device reset timer
module port_timer
	import port_pkg::*;
#(
	parameter int unsigned WIDTH = PORT_CNT_W
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	// Control
	input wire logic clear,
	input wire logic run,
	input wire logic [WIDTH-1:0] limit,
	// Result
	output logic done
);

	typedef struct packed
	{
		logic [WIDTH-1:0] cnt_r;
		logic done_r;
	} port_tmr_s;

	port_tmr_s st_r;
	port_tmr_s st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (clear)
		begin
			st_nxt.cnt_r = '0;
			st_nxt.done_r = 1'b0;
		end
		else if (run && !st_r.done_r)
		begin
			// Saturates at the limit so a long hold cannot wrap around
			if (st_r.cnt_r == limit - WIDTH'(1))
				st_nxt.done_r = 1'b1;
			st_nxt.cnt_r = st_r.cnt_r + WIDTH'(1);
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_r.cnt_r <= '0;
			st_r.done_r <= 1'b0;
		end
		else if (clk_en)
			st_r <= st_nxt;
	end

	assign done = st_r.done_r;

endmodule

// [hdl/power_on_reset_timer.sv]
// Power-on reset sequencer: reset latch and device reset timer
// Contract
// - Power-up sets latch, timer held cleared
// - Timer idle while master clear low
// - Time-out clears latch, ends chip reset
// - Only rst or master clear low retriggers reset
module power_on_reset_timer
	import port_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = PORT_TIMEOUT_CYC
)
(
	// Clock, power-up reset and enable
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	// External reset pin, synchronous to clk
	input wire logic master_clear_n,
	// Core side
	output logic chip_reset,
	output logic timer_running
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed
	{
		port_state_e state_r;
		logic latch_r;
	} port_top_s;

	port_top_s st_r;
	port_top_s st_nxt;
	logic tmr_clear;
	logic tmr_done;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		tmr_clear = 1'b0;
		unique case (st_r.state_r)
			PORT_HOLD:
			begin
				st_nxt.latch_r = 1'b1;
				tmr_clear = 1'b1;
				if (master_clear_n)
					st_nxt.state_r = PORT_COUNT;
			end
			PORT_COUNT:
			begin
				if (!master_clear_n)
				begin
					st_nxt.state_r = PORT_HOLD;
					tmr_clear = 1'b1;
				end
				else if (tmr_done)
				begin
					st_nxt.latch_r = 1'b0;
					st_nxt.state_r = PORT_RUN;
				end
			end
			PORT_RUN:
			begin
				if (!master_clear_n)
				begin
					st_nxt.latch_r = 1'b1;
					st_nxt.state_r = PORT_HOLD;
					tmr_clear = 1'b1;
				end
			end
			default:
			begin
				st_nxt.latch_r = 1'b1;
				st_nxt.state_r = PORT_HOLD;
				tmr_clear = 1'b1;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// power-up sets latch
	// rst sets it, as does master_clear_n low in PORT_RUN; no supply-fall input exists by design
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_r.state_r <= PORT_HOLD;
			st_r.latch_r <= PORT_LATCH_RST;
		end
		else if (clk_en)
			st_r <= st_nxt;
	end

	// ------------------------------------------------------------
	// Timer
	// ------------------------------------------------------------
	port_timer #(
		.WIDTH(PORT_CNT_W)
	) u_device_reset_timer (
		.clk(clk),
		.rst(rst),
		.clk_en(clk_en),
		.clear(tmr_clear),
		.run(st_r.state_r == PORT_COUNT),
		.limit(PORT_CNT_W'(TIMEOUT_CYC)),
		.done(tmr_done)
	);

	assign chip_reset = st_r.latch_r;
	assign timer_running = (st_r.state_r == PORT_COUNT);

endmodule

// [verif/port_ext.sv]
// External reset source model
module port_ext(
	input wire logic clk,
	input wire logic vdd_ok,
	output logic master_clear_n = 1'h0
);
timeunit 1ns;
timeprecision 1ps;
always @(posedge clk) master_clear_n <= #2 vdd_ok;
endmodule

// [verif/port_properties.sv]
// Port assertions of the reset sequencer
module port_chk #(
	parameter int unsigned TIMEOUT_CYC = 720000
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic master_clear_n,
	input wire logic chip_reset,
	input wire logic timer_running
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge clk); endclocking
default disable iff (rst);
// Counts enabled cycles spent counting; a long time-out cannot be a delay range
logic [20:0] run_cnt = 21'h000000;
always_ff @(posedge clk or posedge rst)
begin
	if (rst)
		run_cnt <= 21'h000000;
	else if (clk_en)
		run_cnt <= timer_running ? run_cnt + 21'h000001 : 21'h000000;
end
property p_up; $past(rst) |-> chip_reset && !timer_running; endproperty
a_up: assert property (p_up) else $error("not held");
property p_idle; !master_clear_n && clk_en |=> !timer_running; endproperty
a_idle: assert property (p_idle) else $error("ran early");
property p_end; timer_running |-> run_cnt <= TIMEOUT_CYC + 1; endproperty
a_end: assert property (p_end) else $error("no end");
property p_fall; $rose(chip_reset) |-> !$past(master_clear_n); endproperty
a_fall: assert property (p_fall) else $error("retrigger");
property p_arm; !master_clear_n && clk_en |=> chip_reset; endproperty
a_arm: assert property (p_arm) else $error("no rearm");
endmodule
bind power_on_reset_timer port_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk(.clk(clk), .rst(rst), .clk_en(clk_en),
	.master_clear_n(master_clear_n), .chip_reset(chip_reset), .timer_running(timer_running));

// [verif/power_on_reset_timer_tb_top.sv]
// Bench for the power-on reset timer
module power_on_reset_timer_tb_top;
timeunit 1ns;
timeprecision 1ps;
localparam int TO = 10;
logic clk = 0, rst = 1, ok = 0, en = 1, mc_n, cr, tr;
int miscompares = 0, tests_run = 0, n;
power_on_reset_timer #(.TIMEOUT_CYC(TO)) u_power_on_reset_timer(.clk(clk), .rst(rst), .clk_en(en),
	.master_clear_n(mc_n), .chip_reset(cr), .timer_running(tr));
port_ext u_port_ext(.clk(clk), .vdd_ok(ok), .master_clear_n(mc_n));
initial forever #12.5 clk = ~clk;
task chk(string s, logic v, e);
	tests_run++;
	if (v !== e)
	begin
		miscompares++;
		$display("[FAIL] %s exp %b got %b", s, e, v);
	end
endtask
task cyc(int k);
	repeat (k) @(posedge clk);
	#1;
endtask
task t_up;
	cyc(20);
	rst = 0;
	cyc(6);
	chk("reset", cr, 1'h1);
	chk("idle", tr, 1'h0);
endtask
task t_por;
	rst = 1;
	cyc(2);
	chk("por reset", cr, 1'h1);
	chk("por idle", tr, 1'h0);
	rst = 0;
	cyc(2);
	chk("por held", cr, 1'h1);
endtask
task t_frz;
	en = 0;
	cyc(TO + 6);
	chk("frozen", cr, 1'h1);
	chk("frozen run", tr, 1'h1);
	en = 1;
endtask
// Pulse low first, so a running count must restart
task t_rel;
	ok = 0;
	cyc(1);
	ok = 1;
	for (n = 0; cr === 1'h1 && n < 50; n++)
		cyc(1);
	chk("time", n inside {TO + 3, TO + 4}, 1'h1);
	chk("stopped", tr, 1'h0);
endtask
task t_arm;
	ok = 0;
	cyc(1);
	ok = 1;
	cyc(3);
	chk("rearm", cr, 1'h1);
	chk("recount", tr, 1'h1);
endtask
task give_verdict;
	$display("%0d checks %0d miscompares", tests_run, miscompares);
	if (miscompares == 0 && tests_run > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
endtask
initial
begin
	t_up;
	t_rel;
	cyc(40);
	chk("hold", cr, 1'h0);
	t_arm;
	t_frz;
	cyc(4);
	t_rel;
	t_por;
	give_verdict;
end
initial
begin
	repeat (5000) @(posedge clk);
	miscompares++;
	give_verdict;
end
endmodule
